// file: ui_filter_timestamp_cfg_regs.svh
`ifndef UI_FILTER_TIMESTAMP_CFG_REGS_SVH
`define UI_FILTER_TIMESTAMP_CFG_REGS_SVH

// Register addresses
`define GYRO_TEMP_FILTER_CFG_ADDR 8'h51
`define UI_FILTER_BANDWIDTH_CFG_ADDR 8'h52
`define ACCEL_FILTER_ORDER_CFG_ADDR 8'h53
`define TIMESTAMP_CFG_ADDR 8'h54

// Reset values
`define GYRO_TEMP_FILTER_CFG_RST 8'h16
`define UI_FILTER_BANDWIDTH_CFG_RST 8'h11
`define ACCEL_FILTER_ORDER_CFG_RST 8'h0D
`define TIMESTAMP_CFG_RST 8'h23

// Writable bit masks; reserved bits keep their reset value
`define GYRO_TEMP_FILTER_CFG_WMASK 8'hEF
`define UI_FILTER_BANDWIDTH_CFG_WMASK 8'hFF
`define ACCEL_FILTER_ORDER_CFG_WMASK 8'h1E
`define TIMESTAMP_CFG_WMASK 8'h1F

// Field positions
`define TEMP_BW_MSB 7
`define TEMP_BW_LSB 5
`define GYRO_ORD_MSB 3
`define GYRO_ORD_LSB 2
`define GYRO_DEC_MSB 1
`define GYRO_DEC_LSB 0
`define ACCEL_BW_MSB 7
`define ACCEL_BW_LSB 4
`define GYRO_BW_MSB 3
`define GYRO_BW_LSB 0
`define ACCEL_ORD_MSB 4
`define ACCEL_ORD_LSB 3
`define ACCEL_DEC_MSB 2
`define ACCEL_DEC_LSB 1
`define TS_VIS_BIT 4
`define TS_RES_BIT 3
`define TS_DELTA_BIT 2
`define TS_FRAME_SYNC_INPUT_BIT 1
`define TS_EN_BIT 0

// Timing
`define CLK_FREQ_HZ 50000000
`define TS_TICK_US 1
`define TS_TICK_CYCLES ((`CLK_FREQ_HZ / 1000000) * `TS_TICK_US)
`define TS_COARSE_DIV 16

`endif

// file: ui_filter_timestamp_pkg.sv
package ui_filter_timestamp_pkg;

	typedef enum logic [1:0] {
		ORD_FIRST = 2'h0,
		ORD_SECOND = 2'h1,
		ORD_THIRD = 2'h2,
		ORD_RESERVED = 2'h3
	} filter_order_e;

	typedef enum logic [1:0] {
		ACCEL_OFF = 2'h0,
		ACCEL_OFF_ALT = 2'h1,
		ACCEL_LOW_POWER = 2'h2,
		ACCEL_LOW_NOISE = 2'h3
	} accel_mode_e;

	// Bandwidth kind decoded from a bandwidth code
	typedef enum logic [2:0] {
		BW_HALF_ODR = 3'h0,
		BW_DIVIDED = 3'h1,
		BW_LOW_LAT_400 = 3'h2,
		BW_LOW_LAT_200 = 3'h3,
		BW_AVG_1X = 3'h4,
		BW_AVG_16X = 3'h5,
		BW_RESERVED = 3'h7
	} bw_kind_e;

	typedef struct packed {
		bw_kind_e kind;
		logic [5:0] divisor;
	} bw_sel_s;

	typedef struct packed {
		logic we;
		logic re;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic [12:0] temp_bw_hz;
		logic [15:0] temp_latency_us;
		filter_order_e gyro_order;
		logic gyro_order_valid;
		logic gyro_dec_valid;
		bw_sel_s accel_bw;
		bw_sel_s gyro_bw;
		filter_order_e accel_order;
		logic accel_order_valid;
		logic accel_dec_valid;
		logic ts_enable;
		logic ts_frame_sync_input_enable;
		logic ts_delta;
		logic ts_coarse;
	} filter_cfg_s;

	typedef struct packed {
		logic [5:0] prescale;
		logic [3:0] coarse;
		logic [19:0] count;
		logic [19:0] frame_sync_input_stamp;
	} ts_state_s;

endpackage

// file: bw_code_decoder.sv
`timescale 1ns/1ps

module bw_code_decoder
	import ui_filter_timestamp_pkg::*;
(
	// Code and mode
	input wire logic [3:0] code_i,
	input wire logic low_power_i,
	// Decoded selection
	output bw_sel_s sel_o
);

	always_comb begin
		sel_o.kind = BW_RESERVED;
		sel_o.divisor = 6'h00;
		if (low_power_i) begin
			// [R6] Averaging codes
			case (code_i)
				4'h1: sel_o.kind = BW_AVG_1X;
				4'h6: sel_o.kind = BW_AVG_16X;
				default: sel_o.kind = BW_RESERVED;
			endcase
		end else begin
			// [R4] Divider table
			case (code_i)
				4'h0: begin
					sel_o.kind = BW_HALF_ODR;
					sel_o.divisor = 6'h02;
				end
				4'h1: begin
					sel_o.kind = BW_DIVIDED;
					sel_o.divisor = 6'h04;
				end
				4'h2: begin
					sel_o.kind = BW_DIVIDED;
					sel_o.divisor = 6'h05;
				end
				4'h3: begin
					sel_o.kind = BW_DIVIDED;
					sel_o.divisor = 6'h08;
				end
				4'h4: begin
					sel_o.kind = BW_DIVIDED;
					sel_o.divisor = 6'h0A;
				end
				4'h5: begin
					sel_o.kind = BW_DIVIDED;
					sel_o.divisor = 6'h10;
				end
				4'h6: begin
					sel_o.kind = BW_DIVIDED;
					sel_o.divisor = 6'h14;
				end
				4'h7: begin
					sel_o.kind = BW_DIVIDED;
					sel_o.divisor = 6'h28;
				end
				// [R5] Low-latency options
				4'hE: sel_o.kind = BW_LOW_LAT_400;
				4'hF: sel_o.kind = BW_LOW_LAT_200;
				default: sel_o.kind = BW_RESERVED;
			endcase
		end
	end

endmodule

// file: ui_filter_timestamp_config.sv
`timescale 1ns/1ps
`include "ui_filter_timestamp_cfg_regs.svh"

// Summary of operation
// [R1] Temperature bandwidth code sets bandwidth, latency
// [R2] Gyro filter order 1st/2nd/3rd, 11 reserved
// [R3] Gyro second decimator accepts only third order
// [R4] Accel low-noise bandwidth: OUTPUT_SAMPLE_RATE/2 or dividers
// [R5] Codes 14, 15 select low-latency decimation
// [R6] Accel low-power: 1x or 16x averaging
// [R7] Gyro bandwidth uses accel low-noise encoding
// [R8] Accel filter order 1st/2nd/3rd, 11 reserved
// [R9] Accel second decimator accepts only third order
// [R10] Visibility bit zeroes timestamp reads when clear
// [R11] Resolution bit: 1 us or 16 us
// [R12] Delta bit: time since last OUTPUT_SAMPLE_RATE event
// [R13] Frame-sync enable captures stamp on sync
// [R14] Host also sets queue frame-sync enable
// [R15] Enable bit turns timestamp counter on
// [R16] Accel mode 10 low-power, 11 low-noise
// [R17] Host avoids reserved codes and bits
// [R18] Reset values load; reserved bits hold them

module ui_filter_timestamp_config
	import ui_filter_timestamp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Serial interface register port
	input wire reg_req_s req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	// System context
	input wire accel_mode_e accel_mode_i,
	input wire logic odr_event_i,
	input wire logic frame_sync_input_i,
	// Decoded configuration
	output filter_cfg_s cfg_o,
	// Timestamp values
	output logic [19:0] timestamp_count_value_o,
	output logic [19:0] frame_sync_stamp_o
);

	typedef struct packed {
		logic [7:0] gyro_temp_filter_cfg;
		logic [7:0] ui_filter_bandwidth_cfg;
		logic [7:0] accel_filter_order_cfg;
		logic [7:0] timestamp_cfg;
		logic [7:0] rdata;
		logic rvalid;
		logic sync_d;
		ts_state_s ts;
		filter_cfg_s cfg;
		logic [19:0] ts_read;
	} state_s;

	localparam logic [5:0] TICK_LAST = 6'(`TS_TICK_CYCLES - 1);
	localparam logic [3:0] COARSE_LAST = 4'(`TS_COARSE_DIV - 1);

	state_s state_r;
	state_s state_nxt;
	bw_sel_s accel_sel;
	bw_sel_s gyro_sel;
	logic accel_lp;
	logic tick;
	logic step;

	// [R16] Mode picks bandwidth interpretation
	assign accel_lp = (accel_mode_i == ACCEL_LOW_POWER);

	bw_code_decoder u_accel_bw (
		.code_i(state_r.ui_filter_bandwidth_cfg[`ACCEL_BW_MSB:`ACCEL_BW_LSB]),
		.low_power_i(accel_lp),
		.sel_o(accel_sel)
	);

	// [R7] Gyro is always low-noise encoded
	bw_code_decoder u_gyro_bw (
		.code_i(state_r.ui_filter_bandwidth_cfg[`GYRO_BW_MSB:`GYRO_BW_LSB]),
		.low_power_i(1'b0),
		.sel_o(gyro_sel)
	);

	assign tick = (state_r.ts.prescale == TICK_LAST);
	assign step = tick && (!state_r.timestamp_cfg[`TS_RES_BIT] || state_r.ts.coarse == COARSE_LAST);

	always_comb begin
		state_nxt = state_r;
		state_nxt.rvalid = 1'b0;
		state_nxt.sync_d = frame_sync_input_i;

		// [R18] Only writable bits take host data
		if (req_i.we) begin
			case (req_i.addr)
				`GYRO_TEMP_FILTER_CFG_ADDR: state_nxt.gyro_temp_filter_cfg =
					(req_i.wdata & `GYRO_TEMP_FILTER_CFG_WMASK) |
					(`GYRO_TEMP_FILTER_CFG_RST & ~`GYRO_TEMP_FILTER_CFG_WMASK);
				`UI_FILTER_BANDWIDTH_CFG_ADDR: state_nxt.ui_filter_bandwidth_cfg = req_i.wdata;
				`ACCEL_FILTER_ORDER_CFG_ADDR: state_nxt.accel_filter_order_cfg =
					(req_i.wdata & `ACCEL_FILTER_ORDER_CFG_WMASK) |
					(`ACCEL_FILTER_ORDER_CFG_RST & ~`ACCEL_FILTER_ORDER_CFG_WMASK);
				`TIMESTAMP_CFG_ADDR: state_nxt.timestamp_cfg =
					(req_i.wdata & `TIMESTAMP_CFG_WMASK) |
					(`TIMESTAMP_CFG_RST & ~`TIMESTAMP_CFG_WMASK);
				default: state_nxt.rdata = state_r.rdata;
			endcase
		end

		if (req_i.re) begin
			state_nxt.rvalid = 1'b1;
			case (req_i.addr)
				`GYRO_TEMP_FILTER_CFG_ADDR: state_nxt.rdata = state_r.gyro_temp_filter_cfg;
				`UI_FILTER_BANDWIDTH_CFG_ADDR: state_nxt.rdata = state_r.ui_filter_bandwidth_cfg;
				`ACCEL_FILTER_ORDER_CFG_ADDR: state_nxt.rdata = state_r.accel_filter_order_cfg;
				`TIMESTAMP_CFG_ADDR: state_nxt.rdata = state_r.timestamp_cfg;
				default: state_nxt.rdata = 8'h00;
			endcase
		end

		// [R15] Counter runs only while enabled
		if (!state_r.timestamp_cfg[`TS_EN_BIT]) begin
			state_nxt.ts.prescale = 6'h00;
			state_nxt.ts.coarse = 4'h0;
			state_nxt.ts.count = 20'h00000;
		end else begin
			state_nxt.ts.prescale = tick ? 6'h00 : state_r.ts.prescale + 6'h01;
			// [R11] 1 us or 16 us per count
			if (tick && state_r.timestamp_cfg[`TS_RES_BIT]) begin
				state_nxt.ts.coarse = state_r.ts.coarse + 4'h1;
			end
			// [R12] Delta mode restarts on each OUTPUT_SAMPLE_RATE event
			if (state_r.timestamp_cfg[`TS_DELTA_BIT] && odr_event_i) begin
				state_nxt.ts.count = 20'h00000;
			end else if (step) begin
				state_nxt.ts.count = state_r.ts.count + 20'h00001;
			end
		end

		// [R13] Capture on frame-sync rising edge
		if (state_r.timestamp_cfg[`TS_FRAME_SYNC_INPUT_BIT] && state_r.timestamp_cfg[`TS_EN_BIT] &&
			frame_sync_input_i && !state_r.sync_d) begin
			state_nxt.ts.frame_sync_input_stamp = state_r.ts.count;
		end

		// [R10] Hidden timestamp reads as zeros
		state_nxt.ts_read = state_r.timestamp_cfg[`TS_VIS_BIT] ? state_r.ts.count : 20'h00000;

		// [R1] Temperature low-pass bandwidth and latency
		case (state_r.gyro_temp_filter_cfg[`TEMP_BW_MSB:`TEMP_BW_LSB])
			3'h0: begin
				state_nxt.cfg.temp_bw_hz = 13'hFA0;
				state_nxt.cfg.temp_latency_us = 16'h007D;
			end
			3'h1: begin
				state_nxt.cfg.temp_bw_hz = 13'h0AA;
				state_nxt.cfg.temp_latency_us = 16'h03E8;
			end
			3'h2: begin
				state_nxt.cfg.temp_bw_hz = 13'h052;
				state_nxt.cfg.temp_latency_us = 16'h07D0;
			end
			3'h3: begin
				state_nxt.cfg.temp_bw_hz = 13'h028;
				state_nxt.cfg.temp_latency_us = 16'h0FA0;
			end
			3'h4: begin
				state_nxt.cfg.temp_bw_hz = 13'h014;
				state_nxt.cfg.temp_latency_us = 16'h1F40;
			end
			3'h5: begin
				state_nxt.cfg.temp_bw_hz = 13'h00A;
				state_nxt.cfg.temp_latency_us = 16'h3E80;
			end
			default: begin
				state_nxt.cfg.temp_bw_hz = 13'h005;
				state_nxt.cfg.temp_latency_us = 16'h7D00;
			end
		endcase

		// [R2] Gyro filter order
		state_nxt.cfg.gyro_order =
			filter_order_e'(state_r.gyro_temp_filter_cfg[`GYRO_ORD_MSB:`GYRO_ORD_LSB]);
		state_nxt.cfg.gyro_order_valid = (state_nxt.cfg.gyro_order != ORD_RESERVED);
		// [R3] Only third order accepted
		state_nxt.cfg.gyro_dec_valid =
			(state_r.gyro_temp_filter_cfg[`GYRO_DEC_MSB:`GYRO_DEC_LSB] == 2'h2);
		state_nxt.cfg.accel_bw = accel_sel;
		state_nxt.cfg.gyro_bw = gyro_sel;
		// [R8] Accel filter order
		state_nxt.cfg.accel_order =
			filter_order_e'(state_r.accel_filter_order_cfg[`ACCEL_ORD_MSB:`ACCEL_ORD_LSB]);
		state_nxt.cfg.accel_order_valid = (state_nxt.cfg.accel_order != ORD_RESERVED);
		// [R9] Only third order accepted
		state_nxt.cfg.accel_dec_valid =
			(state_r.accel_filter_order_cfg[`ACCEL_DEC_MSB:`ACCEL_DEC_LSB] == 2'h2);
		state_nxt.cfg.ts_enable = state_r.timestamp_cfg[`TS_EN_BIT];
		// [R14] Queue propagation is gated elsewhere
		state_nxt.cfg.ts_frame_sync_input_enable = state_r.timestamp_cfg[`TS_FRAME_SYNC_INPUT_BIT];
		state_nxt.cfg.ts_delta = state_r.timestamp_cfg[`TS_DELTA_BIT];
		state_nxt.cfg.ts_coarse = state_r.timestamp_cfg[`TS_RES_BIT];
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= '0;
			state_r.gyro_temp_filter_cfg <= `GYRO_TEMP_FILTER_CFG_RST;
			state_r.ui_filter_bandwidth_cfg <= `UI_FILTER_BANDWIDTH_CFG_RST;
			state_r.accel_filter_order_cfg <= `ACCEL_FILTER_ORDER_CFG_RST;
			state_r.timestamp_cfg <= `TIMESTAMP_CFG_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign rdata_o = state_r.rdata;
	assign rvalid_o = state_r.rvalid;
	assign cfg_o = state_r.cfg;
	assign timestamp_count_value_o = state_r.ts_read;
	assign frame_sync_stamp_o = state_r.ts.frame_sync_input_stamp;

	a_reserved_bits: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		state_r.timestamp_cfg[7:5] == 3'h1 && state_r.accel_filter_order_cfg[0] == 1'b1)
		else $error("reserved bits changed");

	a_ts_hidden: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
		!state_r.timestamp_cfg[`TS_VIS_BIT] |=> timestamp_count_value_o == 20'h00000)
		else $error("hidden timestamp not zero");

	a_ts_disabled: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		!state_r.timestamp_cfg[`TS_EN_BIT] |=> state_r.ts.count == 20'h00000)
		else $error("disabled timestamp counts");

	a_ts_fine_step: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		state_r.timestamp_cfg[4:0] == 5'h01 && state_nxt.timestamp_cfg == state_r.timestamp_cfg
		&& tick |=> state_r.ts.count == $past(state_r.ts.count) + 20'h00001)
		else $error("fine tick missed");

	a_ts_delta_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
		state_r.timestamp_cfg[`TS_EN_BIT] && state_r.timestamp_cfg[`TS_DELTA_BIT] && odr_event_i
		|=> state_r.ts.count == 20'h00000)
		else $error("delta not restarted");

	a_frame_sync_input_capture: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
		state_r.timestamp_cfg[1:0] == 2'h3 && frame_sync_input_i && !state_r.sync_d
		|=> frame_sync_stamp_o == $past(state_r.ts.count))
		else $error("frame sync stamp missed");

	a_read_answer: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		req_i.re && req_i.addr == `TIMESTAMP_CFG_ADDR && !req_i.we
		|=> rvalid_o && rdata_o == $past(state_r.timestamp_cfg))
		else $error("read data wrong");

	a_gyro_dec: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		cfg_o.gyro_dec_valid |-> $past(state_r.gyro_temp_filter_cfg[1:0]) == 2'h2)
		else $error("gyro decimator valid wrong");

	a_accel_lp: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		accel_lp && state_r.ui_filter_bandwidth_cfg[7:4] == 4'h6 |=> cfg_o.accel_bw.kind == BW_AVG_16X)
		else $error("16x averaging not selected");

	a_temp_bw: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		state_r.gyro_temp_filter_cfg[7:5] == 3'h0 |=> cfg_o.temp_bw_hz == 13'hFA0)
		else $error("temperature bandwidth wrong");

	// Decoded order and bandwidth fields
	a_gyro_order_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		state_r.gyro_temp_filter_cfg[3:2] == 2'h3
		|=> !cfg_o.gyro_order_valid)
		else $error("gyro reserved order accepted");

	a_gyro_order_third: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		state_r.gyro_temp_filter_cfg[3:2] == 2'h2
		|=> cfg_o.gyro_order == ORD_THIRD && cfg_o.gyro_order_valid)
		else $error("gyro third order wrong");

	a_accel_order_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		state_r.accel_filter_order_cfg[4:3] == 2'h3
		|=> !cfg_o.accel_order_valid)
		else $error("accel reserved order accepted");

	a_accel_dec: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
		cfg_o.accel_dec_valid
		|-> $past(state_r.accel_filter_order_cfg[2:1]) == 2'h2)
		else $error("accel decimator valid wrong");

	a_accel_ln_div: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		!accel_lp && state_r.ui_filter_bandwidth_cfg[7:4] == 4'h7
		|=> cfg_o.accel_bw.kind == BW_DIVIDED && cfg_o.accel_bw.divisor == 6'h28)
		else $error("accel divide by forty wrong");

	a_accel_ln_rsvd: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		!accel_lp && state_r.ui_filter_bandwidth_cfg[7:4] == 4'h8
		|=> cfg_o.accel_bw.kind == BW_RESERVED)
		else $error("accel reserved bandwidth accepted");

	a_gyro_low_lat: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
		state_r.ui_filter_bandwidth_cfg[3:0] == 4'hE
		|=> cfg_o.gyro_bw.kind == BW_LOW_LAT_400)
		else $error("gyro low latency wrong");

	a_gyro_half: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		state_r.ui_filter_bandwidth_cfg[3:0] == 4'h0
		|=> cfg_o.gyro_bw.kind == BW_HALF_ODR && cfg_o.gyro_bw.divisor == 6'h02)
		else $error("gyro half rate wrong");

	a_accel_lp_1x: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		accel_lp && state_r.ui_filter_bandwidth_cfg[7:4] == 4'h1
		|=> cfg_o.accel_bw.kind == BW_AVG_1X)
		else $error("1x averaging not selected");

	a_mode_ln: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		accel_mode_i == ACCEL_LOW_NOISE && state_r.ui_filter_bandwidth_cfg[7:4] == 4'h6
		|=> cfg_o.accel_bw.kind == BW_DIVIDED)
		else $error("low noise decode not used");

	a_temp_slow: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		state_r.gyro_temp_filter_cfg[7:5] == 3'h7
		|=> cfg_o.temp_bw_hz == 13'h005 && cfg_o.temp_latency_us == 16'h7D00)
		else $error("slowest temperature setting wrong");

	// Register bank and timestamp
	a_gyro_rsvd_bit: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		state_r.gyro_temp_filter_cfg[4] == 1'b1)
		else $error("gyro reserved bit changed");

	a_rvalid_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		!req_i.re
		|=> !rvalid_o)
		else $error("answer without read");

	a_ts_coarse_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		state_r.timestamp_cfg[4:0] == 5'h09 && state_nxt.timestamp_cfg == state_r.timestamp_cfg
		&& !step |=> state_r.ts.count == $past(state_r.ts.count))
		else $error("coarse count moved early");

	c_delta_clear: cover property (@(posedge clk_i) disable iff (rst_i)
		state_r.timestamp_cfg[`TS_DELTA_BIT] && odr_event_i);
	c_read: cover property (@(posedge clk_i) disable iff (rst_i)
		rvalid_o && rdata_o == `TIMESTAMP_CFG_RST);
	c_frame_sync_input: cover property (@(posedge clk_i) disable iff (rst_i)
		state_r.timestamp_cfg[1] && frame_sync_input_i && !state_r.sync_d);
	c_coarse: cover property (@(posedge clk_i) disable iff (rst_i)
		state_r.timestamp_cfg[`TS_RES_BIT] && step);
	c_low_latency: cover property (@(posedge clk_i) disable iff (rst_i)
		cfg_o.gyro_bw.kind == BW_LOW_LAT_200);

endmodule

// file: host_bus_model.sv
`timescale 1ns/1ps

module host_bus_model
	import ui_filter_timestamp_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Register request
	output reg_req_s req_o
);
	logic [7:0] exp_q[$];

	initial begin
		req_o = '0;
	end

	// One-cycle strobe; a read notes its expected byte first
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		if (!wr) begin
			exp_q.push_back(d);
		end
		@(posedge clk_i);
		req_o <= '{we: wr, re: !wr, addr: a, wdata: wr ? d : 8'h00};
		@(posedge clk_i);
		req_o <= '0;
	endtask
endmodule

// file: ui_filter_timestamp_config_tb.sv
`timescale 1ns/1ps
`include "ui_filter_timestamp_cfg_regs.svh"

module ui_filter_timestamp_config_tb
	import ui_filter_timestamp_pkg::*;
;
	logic clk_i;
	logic rst_i;
	reg_req_s req;
	logic [7:0] rdata;
	logic rvalid;
	accel_mode_e accel_mode;
	logic odr_event;
	logic frame_sync_input;
	filter_cfg_s cfg;
	logic [19:0] ts_value;
	logic [19:0] fs_stamp;
	int err_count;
	int checks_done;
	int seed;
	logic [7:0] rst_tab[4] = '{`GYRO_TEMP_FILTER_CFG_RST, `UI_FILTER_BANDWIDTH_CFG_RST,
		`ACCEL_FILTER_ORDER_CFG_RST, `TIMESTAMP_CFG_RST};
	logic [7:0] msk_tab[4] = '{`GYRO_TEMP_FILTER_CFG_WMASK, `UI_FILTER_BANDWIDTH_CFG_WMASK,
		`ACCEL_FILTER_ORDER_CFG_WMASK, `TIMESTAMP_CFG_WMASK};
	logic [5:0] div_tab[8] = '{6'h00, 6'h04, 6'h05, 6'h08, 6'h0A, 6'h10, 6'h14, 6'h28};
	logic [12:0] tbw[8] = '{13'hFA0, 13'hAA, 13'h52, 13'h28, 13'h14, 13'hA, 13'h5, 13'h5};
	logic [15:0] tlat[8] = '{16'h7D, 16'h3E8, 16'h7D0, 16'hFA0, 16'h1F40, 16'h3E80,
		16'h7D00, 16'h7D00};

	host_bus_model i_host (.clk_i(clk_i), .req_o(req));

	ui_filter_timestamp_config i_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.req_i(req),
		.rdata_o(rdata),
		.rvalid_o(rvalid),
		.accel_mode_i(accel_mode),
		.odr_event_i(odr_event),
		.frame_sync_input_i(frame_sync_input),
		.cfg_o(cfg),
		.timestamp_count_value_o(ts_value),
		.frame_sync_stamp_o(fs_stamp)
	);

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	function automatic bw_kind_e exp_kind(input logic [3:0] c, input logic lp);
		if (lp) return (c == 4'h1) ? BW_AVG_1X : (c == 4'h6) ? BW_AVG_16X : BW_RESERVED;
		if (c == 4'h0) return BW_HALF_ODR;
		if (c < 4'h8) return BW_DIVIDED;
		if (c < 4'hE) return BW_RESERVED;
		return (c == 4'hE) ? BW_LOW_LAT_400 : BW_LOW_LAT_200;
	endfunction

	// Each read answer is matched with the oldest noted byte
	always @(negedge clk_i) begin
		if (rvalid === 1'b1) begin
			cmp_rd(rdata, (i_host.exp_q.size() > 0) ? i_host.exp_q.pop_front() : 8'hXX);
		end
	end

	initial begin
		repeat (40000) @(posedge clk_i);
		err_count++;
		complete_run();
	end

	initial begin
		logic [7:0] d;
		logic [19:0] t0;
		seed = 75;
		err_count = 0;
		checks_done = 0;
		rst_i = 1'b1;
		accel_mode = ACCEL_LOW_NOISE;
		odr_event = 1'b0;
		frame_sync_input = 1'b0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 4; i++) i_host.xfer(0, 8'h51 + i[7:0], rst_tab[i]);
		i_host.xfer(0, 8'h55, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			i_host.xfer(1, 8'h51 + i[7:0], d);
			i_host.xfer(1, 8'h55, d);
			i_host.xfer(0, 8'h51 + i[7:0], (d & msk_tab[i]) | (rst_tab[i] & ~msk_tab[i]));
		end
		i_host.xfer(0, 8'h55, 8'h00);
		for (int c = 0; c < 8; c++) begin
			i_host.xfer(1, 8'h51, {c[2:0], 5'h0A});
			wait_cyc(2);
			cmp_val(32'(cfg.temp_bw_hz), 32'(tbw[c]));
			cmp_val(32'(cfg.temp_latency_us), 32'(tlat[c]));
		end
		for (int c = 0; c < 4; c++) begin
			i_host.xfer(1, 8'h51, {4'h0, c[1:0], c[1:0]});
			i_host.xfer(1, 8'h53, {3'h0, c[1:0], c[1:0], 1'b0});
			wait_cyc(2);
			cmp_val(32'(cfg.gyro_order), 32'(c));
			cmp_val(32'(cfg.gyro_order_valid), 32'(c != 3));
			cmp_val(32'(cfg.gyro_dec_valid), 32'(c == 2));
			cmp_val(32'(cfg.accel_order), 32'(c));
			cmp_val(32'(cfg.accel_order_valid), 32'(c != 3));
			cmp_val(32'(cfg.accel_dec_valid), 32'(c == 2));
		end
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_i);
			accel_mode <= accel_mode_e'(m);
			for (int c = 0; c < 16; c++) begin
				i_host.xfer(1, 8'h52, {c[3:0], c[3:0]});
				wait_cyc(2);
				cmp_val(32'(cfg.accel_bw.kind), 32'(exp_kind(c[3:0], m == 2)));
				cmp_val(32'(cfg.gyro_bw.kind), 32'(exp_kind(c[3:0], 1'b0)));
				if (c > 0 && c < 8) cmp_val(32'(cfg.gyro_bw.divisor), 32'(div_tab[c]));
				if (m == 3 && c > 0 && c < 8) begin
					cmp_val(32'(cfg.accel_bw.divisor), 32'(div_tab[c]));
				end
			end
		end
		i_host.xfer(1, 8'h54, 8'h03);
		wait_cyc(200);
		cmp_val(32'(ts_value), 32'h0);
		i_host.xfer(1, 8'h54, 8'h11);
		wait_cyc(20);
		t0 = ts_value;
		wait_cyc(500);
		cmp_val(32'(20'(ts_value - t0)), 32'hA);
		i_host.xfer(1, 8'h54, 8'h19);
		wait_cyc(20);
		t0 = ts_value;
		wait_cyc(1600);
		cmp_val(32'(20'(ts_value - t0)), 32'h2);
		i_host.xfer(1, 8'h54, 8'h15);
		wait_cyc(100);
		@(posedge clk_i);
		odr_event <= 1'b1;
		@(posedge clk_i);
		odr_event <= 1'b0;
		wait_cyc(1);
		cmp_val(32'(ts_value), 32'h0);
		// Queue stamp enable lives outside; only the stamp is seen here
		i_host.xfer(1, 8'h54, 8'h13);
		wait_cyc(100);
		@(posedge clk_i);
		frame_sync_input <= 1'b1;
		wait_cyc(3);
		t0 = fs_stamp;
		cmp_val(32'(20'(ts_value - t0) < 20'h2), 32'h1);
		@(posedge clk_i);
		frame_sync_input <= 1'b0;
		i_host.xfer(1, 8'h54, 8'h11);
		wait_cyc(100);
		@(posedge clk_i);
		frame_sync_input <= 1'b1;
		wait_cyc(3);
		cmp_val(32'(fs_stamp), 32'(t0));
		i_host.xfer(1, 8'h54, 8'h10);
		wait_cyc(5);
		cmp_val(32'(ts_value), 32'h0);
		wait_cyc(200);
		cmp_val(32'(ts_value), 32'h0);
		complete_run();
	end
endmodule
